// >>> hdl/cfg_params.svh
// Offsets, field positions and reset values of the configuration bank
`ifndef CFG_PARAMS_SVH
`define CFG_PARAMS_SVH
`define IDX_SERIAL_TWO_BASE 8'h25
`define IDX_RESERVED_A 8'h26
`define IDX_RESERVED_B 8'h27
`define IDX_SERIAL_IRQ_SEL 8'h28
`define IDX_PIN_IRQ_MODE 8'h29
`define IDX_PIN_IRQ_TWO_THREE 8'h2a
`define IDX_FAST_IR_BASE 8'h2b
`define RST_SERIAL_TWO_BASE 8'h00
`define RST_RESERVED_A 8'hff
`define RST_RESERVED_B 8'h00
`define RST_SERIAL_IRQ_SEL 8'h00
`define RST_PIN_IRQ_MODE 8'h80
`define RST_PIN_IRQ_TWO_THREE 8'h00
`define RST_FAST_IR_BASE 8'h00
`define WMASK_SERIAL_TWO_BASE 8'hfe
`define WMASK_PIN_IRQ_MODE 8'h9f
`define MODE_PIN_SEL_BIT 4
`define MODE_SIRQ_EN_BIT 7
`define SER2_ADDR_TOP 9
`define FIR_ADDR_TOP 10
`define IRQ_SEL_W 4
`define IRQ_COUNT 16
`define IO_OFFSET_W 3
`define READ_ZERO 8'h00
`endif

// >>> hdl/cfg_pkg.sv
// Shared types of the configuration bank
package cfg_pkg;
  typedef logic [7:0] cfg_byte_t;
  typedef logic [3:0] irq_sel_t;
  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_SER2_BASE = 3'h1,
    REG_RSVD_A = 3'h3,
    REG_RSVD_B = 3'h2,
    REG_SER_IRQ = 3'h6,
    REG_PIN_MODE = 3'h7,
    REG_PIN_IRQ23 = 3'h5,
    REG_FIR_BASE = 3'h4
  } cfg_reg_t;
endpackage

// >>> hdl/decode_if.sv
// Address-decode carrier between the bank and one base decoder
`timescale 1ns/1ps
`default_nettype none
interface decode_if #(
  parameter int TOP = 9
);
  logic [15:0] addr;
  logic valid;
  logic [TOP-3:0] base;
  logic hit;
  modport bank (output addr, output valid, output base, input hit);
  modport decoder (input addr, input valid, input base, output hit);
endinterface
`default_nettype wire

// >>> hdl/base_decoder.sv
// Base address match for an 8-byte-aligned I/O window
`timescale 1ns/1ps
`default_nettype none
`include "cfg_params.svh"
module base_decoder #(
  parameter int TOP = 9
) (
  decode_if.decoder dec
);
  logic upper_clear;
  logic enabled;
  logic base_match;

  generate
    if (TOP < 15)
    begin : g_upper
      assign upper_clear = ~|dec.addr[15:TOP+1];
    end
    else
    begin : g_noupper
      assign upper_clear = 1'b1;
    end
  endgenerate

  // Bits 8 and up all zero leave the window off
  assign enabled = |dec.base[TOP-3:5];
  // Low three address bits never enter the compare
  assign base_match = dec.addr[TOP:3] == dec.base;
  assign dec.hit = dec.valid & enabled & upper_clear & base_match;
endmodule
`default_nettype wire

// >>> hdl/irq_router.sv
// Routes interrupt sources onto numbered interrupt lines
`timescale 1ns/1ps
`default_nettype none
`include "cfg_params.svh"
module irq_router #(
  parameter int SOURCES = 5,
  parameter int LINES = `IRQ_COUNT
) (
  input wire logic [SOURCES*`IRQ_SEL_W-1:0] sel_i,
  input wire logic [SOURCES-1:0] level_i,
  input wire logic [SOURCES-1:0] drive_en_i,
  output logic [LINES-1:0] level_o,
  output logic [LINES-1:0] drive_o
);
  assign level_o[0] = 1'b0;
  assign drive_o[0] = 1'b0;

  genvar n;
  generate
    // Zero in a select field reaches no line, so line 0 stays idle
    for (n = 1; n < LINES; n++)
    begin : g_line
      // Line number as a plain constant, cut to the select width
      localparam int LINE_NUM = n;
      logic [SOURCES-1:0] picks;
      genvar s;
      for (s = 0; s < SOURCES; s++)
      begin : g_src
        assign picks[s] = sel_i[s*`IRQ_SEL_W +: `IRQ_SEL_W]
          == LINE_NUM[`IRQ_SEL_W-1:0];
      end
      // Several sources on one line would be a software fault
      assign drive_o[n] = |(picks & drive_en_i);
      assign level_o[n] = |(picks & drive_en_i & level_i);
    end
  endgenerate
endmodule
`default_nettype wire

// >>> hdl/io_decode_irq_routing_config.sv
// Configuration bank for serial-two and fast-infrared decode and IRQ routing
`timescale 1ns/1ps
`default_nettype none
`include "cfg_params.svh"
module io_decode_irq_routing_config (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_state_i,
  input wire logic cfg_index_wr_i,
  input wire logic cfg_data_wr_i,
  input wire logic cfg_data_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  output logic [7:0] config_index_selector_o,
  input wire logic io_valid_i,
  input wire logic [15:0] io_addr_i,
  output logic serial_two_sel_o,
  output logic fast_ir_engine_sel_o,
  output logic [`IO_OFFSET_W-1:0] io_offset_o,
  input wire logic serial_port_one_irq_i,
  input wire logic serial_port_two_irq_i,
  input wire logic serial_one_aux_output_two_bit_i,
  input wire logic serial_two_aux_output_two_bit_i,
  input wire logic routable_int_pin_one_i,
  input wire logic routable_int_pin_two_i,
  input wire logic routable_int_pin_three_i,
  output logic [`IRQ_COUNT-1:0] irq_level_o,
  output logic [`IRQ_COUNT-1:0] irq_drive_o,
  input wire logic ir_mode_output_i,
  input wire logic shared_pin_i,
  output logic shared_pin_o,
  output logic shared_pin_oe_o,
  output logic third_ir_receive_input_o,
  output logic ir_pin_function_select_o,
  output logic serial_int_clock_run_enable_o
);
  localparam int SOURCES = 5;

  cfg_pkg::cfg_byte_t index_q;
  cfg_pkg::cfg_byte_t serial_two_base_q;
  cfg_pkg::cfg_byte_t reserved_a_q;
  cfg_pkg::cfg_byte_t reserved_b_q;
  cfg_pkg::cfg_byte_t serial_irq_sel_q;
  cfg_pkg::cfg_byte_t pin_mode_q;
  cfg_pkg::cfg_byte_t pin_irq23_q;
  cfg_pkg::cfg_byte_t fast_ir_base_q;
  cfg_pkg::cfg_reg_t reg_sel;
  cfg_pkg::cfg_byte_t read_mux;
  logic wr_ok;
  logic rd_ok;
  logic ser2_hit;
  logic fir_hit;
  logic [SOURCES*`IRQ_SEL_W-1:0] route_sel;
  logic [SOURCES-1:0] route_level;
  logic [SOURCES-1:0] route_en;
  logic [`IRQ_COUNT-1:0] line_level;
  logic [`IRQ_COUNT-1:0] line_drive;

  decode_if #(.TOP(`SER2_ADDR_TOP)) ser2_dec ();
  decode_if #(.TOP(`FIR_ADDR_TOP)) fir_dec ();

  // Index decode into the bank; other indices belong to other blocks
  always_comb
  begin
    unique case (index_q)
      `IDX_SERIAL_TWO_BASE: reg_sel = cfg_pkg::REG_SER2_BASE;
      `IDX_RESERVED_A: reg_sel = cfg_pkg::REG_RSVD_A;
      `IDX_RESERVED_B: reg_sel = cfg_pkg::REG_RSVD_B;
      `IDX_SERIAL_IRQ_SEL: reg_sel = cfg_pkg::REG_SER_IRQ;
      `IDX_PIN_IRQ_MODE: reg_sel = cfg_pkg::REG_PIN_MODE;
      `IDX_PIN_IRQ_TWO_THREE: reg_sel = cfg_pkg::REG_PIN_IRQ23;
      `IDX_FAST_IR_BASE: reg_sel = cfg_pkg::REG_FIR_BASE;
      default: reg_sel = cfg_pkg::REG_NONE;
    endcase
  end

  assign wr_ok = cfg_state_i & cfg_data_wr_i;
  assign rd_ok = cfg_state_i & cfg_data_rd_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      index_q <= `READ_ZERO;
    else if (cfg_state_i && cfg_index_wr_i)
      index_q <= cfg_wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      serial_two_base_q <= `RST_SERIAL_TWO_BASE;
    else if (wr_ok && reg_sel == cfg_pkg::REG_SER2_BASE)
      serial_two_base_q <= cfg_wdata_i & `WMASK_SERIAL_TWO_BASE;
  end

  // Reserved registers hold their power-up values; writes are dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reserved_a_q <= `RST_RESERVED_A;
      reserved_b_q <= `RST_RESERVED_B;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      serial_irq_sel_q <= `RST_SERIAL_IRQ_SEL;
    else if (wr_ok && reg_sel == cfg_pkg::REG_SER_IRQ)
      serial_irq_sel_q <= cfg_wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_mode_q <= `RST_PIN_IRQ_MODE;
    else if (wr_ok && reg_sel == cfg_pkg::REG_PIN_MODE)
      pin_mode_q <= cfg_wdata_i & `WMASK_PIN_IRQ_MODE;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_irq23_q <= `RST_PIN_IRQ_TWO_THREE;
    else if (wr_ok && reg_sel == cfg_pkg::REG_PIN_IRQ23)
      pin_irq23_q <= cfg_wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fast_ir_base_q <= `RST_FAST_IR_BASE;
    else if (wr_ok && reg_sel == cfg_pkg::REG_FIR_BASE)
      fast_ir_base_q <= cfg_wdata_i;
  end

  always_comb
  begin
    unique case (reg_sel)
      cfg_pkg::REG_SER2_BASE: read_mux = serial_two_base_q;
      cfg_pkg::REG_RSVD_A: read_mux = reserved_a_q;
      cfg_pkg::REG_RSVD_B: read_mux = reserved_b_q;
      cfg_pkg::REG_SER_IRQ: read_mux = serial_irq_sel_q;
      cfg_pkg::REG_PIN_MODE: read_mux = pin_mode_q;
      cfg_pkg::REG_PIN_IRQ23: read_mux = pin_irq23_q;
      cfg_pkg::REG_FIR_BASE: read_mux = fast_ir_base_q;
      cfg_pkg::REG_NONE: read_mux = `READ_ZERO;
    endcase
  end

  // Read data stands until the next read; valid is a one-cycle pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_rdata_o <= `READ_ZERO;
      cfg_rvalid_o <= 1'b0;
    end
    else
    begin
      cfg_rvalid_o <= rd_ok;
      if (rd_ok)
        cfg_rdata_o <= read_mux;
    end
  end

  assign config_index_selector_o = index_q;

  assign ser2_dec.addr = io_addr_i;
  assign ser2_dec.valid = io_valid_i;
  assign ser2_dec.base = serial_two_base_q[7:1];
  assign fir_dec.addr = io_addr_i;
  assign fir_dec.valid = io_valid_i;
  assign fir_dec.base = fast_ir_base_q;

  base_decoder #(.TOP(`SER2_ADDR_TOP)) u_ser2_dec (
    .dec(ser2_dec)
  );
  base_decoder #(.TOP(`FIR_ADDR_TOP)) u_fir_dec (
    .dec(fir_dec)
  );

  assign ser2_hit = ser2_dec.hit;
  assign fir_hit = fir_dec.hit;

  // Overlapping windows are a software fault; serial two wins then
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      serial_two_sel_o <= 1'b0;
      fast_ir_engine_sel_o <= 1'b0;
      io_offset_o <= '0;
    end
    else
    begin
      serial_two_sel_o <= ser2_hit;
      fast_ir_engine_sel_o <= fir_hit & ~ser2_hit;
      io_offset_o <= io_addr_i[`IO_OFFSET_W-1:0];
    end
  end

  // Sources: serial one, serial two, routable pins one to three
  assign route_sel = {pin_irq23_q[7:4], pin_irq23_q[3:0], pin_mode_q[3:0],
    serial_irq_sel_q[3:0], serial_irq_sel_q[7:4]};
  assign route_level = {routable_int_pin_three_i, routable_int_pin_two_i,
    routable_int_pin_one_i, serial_port_two_irq_i, serial_port_one_irq_i};
  assign route_en = {3'b111, serial_two_aux_output_two_bit_i,
    serial_one_aux_output_two_bit_i};

  irq_router #(.SOURCES(SOURCES), .LINES(`IRQ_COUNT)) u_router (
    .sel_i(route_sel),
    .level_i(route_level),
    .drive_en_i(route_en),
    .level_o(line_level),
    .drive_o(line_drive)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_level_o <= '0;
      irq_drive_o <= '0;
    end
    else
    begin
      irq_level_o <= line_level;
      irq_drive_o <= line_drive;
    end
  end

  // Shared pin: drives IR mode when bit 4 clear, else samples receive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shared_pin_o <= 1'b0;
      shared_pin_oe_o <= 1'b0;
      third_ir_receive_input_o <= 1'b0;
    end
    else
    begin
      shared_pin_oe_o <= ~pin_mode_q[`MODE_PIN_SEL_BIT];
      shared_pin_o <= ir_mode_output_i & ~pin_mode_q[`MODE_PIN_SEL_BIT];
      third_ir_receive_input_o <= shared_pin_i
        & pin_mode_q[`MODE_PIN_SEL_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ir_pin_function_select_o <= 1'b0;
      serial_int_clock_run_enable_o <= 1'b0;
    end
    else
    begin
      ir_pin_function_select_o <= pin_mode_q[`MODE_PIN_SEL_BIT];
      serial_int_clock_run_enable_o <= pin_mode_q[`MODE_SIRQ_EN_BIT];
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_write_gated: assert property (
    cfg_data_wr_i && !cfg_state_i |=> $stable(serial_two_base_q)
      && $stable(fast_ir_base_q) && $stable(pin_mode_q)
      && $stable(serial_irq_sel_q) && $stable(pin_irq23_q))
    else $error("config write taken outside config state");

  a_base_bit_zero: assert property (
    rd_ok && reg_sel == cfg_pkg::REG_SER2_BASE |=> cfg_rvalid_o
      && !cfg_rdata_o[0] && cfg_rdata_o == $past(serial_two_base_q))
    else $error("serial two base read wrong");

  a_ser2_disabled: assert property (
    io_valid_i && serial_two_base_q[7:6] == 2'b00 |=> !serial_two_sel_o)
    else $error("serial two claimed while disabled");

  a_ser2_upper: assert property (
    io_valid_i && |io_addr_i[15:10] |=> !serial_two_sel_o)
    else $error("serial two claimed with upper bits set");

  a_ser2_claim: assert property (
    io_valid_i && |serial_two_base_q[7:6] && io_addr_i[15:10] == 6'h00
      && io_addr_i[9:3] == serial_two_base_q[7:1]
      |=> serial_two_sel_o && io_offset_o == $past(io_addr_i[2:0]))
    else $error("serial two match not claimed");

  a_fir_disabled: assert property (
    io_valid_i && fast_ir_base_q[7:5] == 3'h0 |=> !fast_ir_engine_sel_o)
    else $error("fast infrared claimed while disabled");

  a_fir_claim: assert property (
    io_valid_i && |fast_ir_base_q[7:5] && io_addr_i[15:11] == 5'h00
      && io_addr_i[10:3] == fast_ir_base_q && !ser2_hit
      |=> fast_ir_engine_sel_o)
    else $error("fast infrared match not claimed");

  a_mode_reserved: assert property (
    wr_ok && reg_sel == cfg_pkg::REG_PIN_MODE
      |=> pin_mode_q == ($past(cfg_wdata_i) & `WMASK_PIN_IRQ_MODE)
      ##1 pin_mode_q[6:5] == 2'b00)
    else $error("mode reserved bits not zero");

  a_aux_gate: assert property (
    !serial_one_aux_output_two_bit_i && route_sel[3:0] != 4'h0
      && route_sel[3:0] != route_sel[7:4] && route_sel[3:0] != route_sel[11:8]
      && route_sel[3:0] != route_sel[15:12]
      && route_sel[3:0] != route_sel[19:16]
      |=> !irq_drive_o[$past(route_sel[3:0])])
    else $error("serial one line driven with aux bit clear");

  a_pin_function: assert property (
    !pin_mode_q[`MODE_PIN_SEL_BIT] |=> shared_pin_oe_o
      && !third_ir_receive_input_o && !ir_pin_function_select_o)
    else $error("shared pin not driving IR mode");

  a_sirq_reset: assert property (
    $fell(rst_i) |-> pin_mode_q == `RST_PIN_IRQ_MODE
      ##1 serial_int_clock_run_enable_o)
    else $error("mode register reset value wrong");
endmodule
`default_nettype wire

// >>> verification/host_cfg_model.sv
// Host model issuing configuration and I/O cycles
`timescale 1ns/1ps
`default_nettype none
module host_cfg_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic cfg_state_o,
  output logic index_wr_o,
  output logic data_wr_o,
  output logic data_rd_o,
  output logic [7:0] wdata_o,
  output logic io_valid_o,
  output logic [15:0] io_addr_o
);
  initial
  begin
    cfg_state_o = 1'b0;
    index_wr_o = 1'b0;
    data_wr_o = 1'b0;
    data_rd_o = 1'b0;
    wdata_o = 8'h5a;
    io_valid_o = 1'b0;
    io_addr_o = 16'hffff;
  end
  task automatic set_cfg(input logic on);
    @(posedge clk_i);
    cfg_state_o <= on;
  endtask
  task automatic put_index(input logic [7:0] idx);
    @(posedge clk_i);
    index_wr_o <= 1'b1;
    wdata_o <= idx;
    @(posedge clk_i);
    index_wr_o <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    put_index(idx);
    data_wr_o <= 1'b1;
    wdata_o <= (idx == 8'h25) ? (val & 8'hfe) : val;
    @(posedge clk_i);
    data_wr_o <= 1'b0;
    wdata_o <= ~val;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] val);
    int n;
    put_index(idx);
    data_rd_o <= 1'b1;
    @(posedge clk_i);
    data_rd_o <= 1'b0;
    wdata_o <= ~idx;
    n = 0;
    #1;
    while (rvalid_i !== 1'b1 && n < 4)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    // Answer must come exactly one cycle after the read strobe
    val = (rvalid_i === 1'b1 && n == 0) ? rdata_i : 8'hxx;
  endtask
  // Address is scrambled once released so stale matches cannot hide
  task automatic io(input logic [15:0] addr);
    @(posedge clk_i);
    io_valid_o <= 1'b1;
    io_addr_o <= addr;
    @(posedge clk_i);
    io_valid_o <= 1'b0;
    io_addr_o <= ~addr;
    #1;
  endtask
endmodule
`default_nettype wire

// >>> verification/io_decode_irq_routing_config_tb.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module io_decode_irq_routing_config_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cfg_st, idx_wr, dat_wr, dat_rd, rvalid, io_valid;
  logic [7:0] wdata, rdata, idx_q;
  logic [15:0] io_addr, lvl, drv;
  logic ser2_sel, fir_sel, pin_o, pin_oe, third_rx, fsel, sirq_en;
  logic [2:0] offset;
  logic [4:0] src = 5'h0;
  logic [1:0] aux = 2'b0;
  logic ir_mode = 1'b0;
  logic pin_drv = 1'b0;
  wire shared_pin = pin_oe ? pin_o : pin_drv;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  host_cfg_model u_host_cfg_model (.clk_i(clk_i), .rdata_i(rdata),
    .rvalid_i(rvalid), .cfg_state_o(cfg_st), .index_wr_o(idx_wr),
    .data_wr_o(dat_wr), .data_rd_o(dat_rd), .wdata_o(wdata),
    .io_valid_o(io_valid), .io_addr_o(io_addr));
  io_decode_irq_routing_config u_io_decode_irq_routing_config (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_state_i(cfg_st),
    .cfg_index_wr_i(idx_wr), .cfg_data_wr_i(dat_wr),
    .cfg_data_rd_i(dat_rd), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
    .cfg_rvalid_o(rvalid), .config_index_selector_o(idx_q),
    .io_valid_i(io_valid), .io_addr_i(io_addr),
    .serial_two_sel_o(ser2_sel), .fast_ir_engine_sel_o(fir_sel),
    .io_offset_o(offset), .serial_port_one_irq_i(src[0]),
    .serial_port_two_irq_i(src[1]),
    .serial_one_aux_output_two_bit_i(aux[0]),
    .serial_two_aux_output_two_bit_i(aux[1]),
    .routable_int_pin_one_i(src[2]), .routable_int_pin_two_i(src[3]),
    .routable_int_pin_three_i(src[4]), .irq_level_o(lvl),
    .irq_drive_o(drv), .ir_mode_output_i(ir_mode),
    .shared_pin_i(shared_pin), .shared_pin_o(pin_o),
    .shared_pin_oe_o(pin_oe), .third_ir_receive_input_o(third_rx),
    .ir_pin_function_select_o(fsel),
    .serial_int_clock_run_enable_o(sirq_en));
  task automatic end_of_test;
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] i,
                                        input logic [7:0] w);
    case (i)
      8'h25: exp_rd = w & 8'hfe;
      8'h26: exp_rd = 8'hff;
      8'h29: exp_rd = w & 8'h9f;
      8'h28, 8'h2a, 8'h2b: exp_rd = w;
      default: exp_rd = 8'h00;
    endcase
  endfunction
  // Bench cannot run forever if a handshake never comes
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("unexpected %0t timeout", $time);
      end_of_test();
    end
  end
  initial
  begin
    logic [7:0] v, w, i;
    logic [3:0] n;
    logic [15:0] a;
    void'($urandom(32'h4bc0a4bc));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    u_host_cfg_model.set_cfg(1'b1);
    for (i = 8'h24; i <= 8'h2c; i++)
    begin
      u_host_cfg_model.rd(i, v);
      check(v, (i == 8'h29) ? 8'h80 : exp_rd(i, 8'h00), "reset");
    end
    check(idx_q, 8'h2c, "index");
    check({pin_oe, fsel, sirq_en}, 3'b101, "mode reset");
    repeat (3)
      for (i = 8'h25; i <= 8'h2b; i++)
      begin
        w = 8'($urandom);
        u_host_cfg_model.wr(i, w);
        u_host_cfg_model.rd(i, v);
        check(v, exp_rd(i, w), "rw");
      end
    tick(2);
    check({rvalid, rdata}, {1'b0, v}, "rdata stands");
    u_host_cfg_model.wr(8'h28, 8'h00);
    u_host_cfg_model.set_cfg(1'b0);
    u_host_cfg_model.wr(8'h28, 8'h5a);
    u_host_cfg_model.set_cfg(1'b1);
    u_host_cfg_model.rd(8'h28, v);
    check(v, 8'h00, "outside config");
    u_host_cfg_model.wr(8'h2b, 8'h00);
    repeat (8)
    begin
      v = 8'($urandom_range(8'h40, 8'hff)) & 8'hfe;
      u_host_cfg_model.wr(8'h25, v);
      a = {6'h0, v[7:1], 3'($urandom)};
      u_host_cfg_model.io(a);
      check({ser2_sel, offset}, {1'b1, a[2:0]}, "ser2 hit");
      u_host_cfg_model.io(a ^ 16'h0008);
      check(ser2_sel, 1'b0, "ser2 miss");
      u_host_cfg_model.io(a | (16'h0400 << $urandom_range(0, 5)));
      check(ser2_sel, 1'b0, "ser2 high");
      u_host_cfg_model.wr(8'h25, v & 8'h3e);
      u_host_cfg_model.io({8'h0, v[5:1], 3'h0});
      check(ser2_sel, 1'b0, "ser2 off");
    end
    repeat (8)
    begin
      v = 8'($urandom_range(8'h20, 8'hff));
      u_host_cfg_model.wr(8'h2b, v);
      a = {5'h0, v, 3'($urandom)};
      u_host_cfg_model.io(a);
      check({fir_sel, offset}, {1'b1, a[2:0]}, "fir hit");
      u_host_cfg_model.io(a | (16'h0800 << $urandom_range(0, 4)));
      check(fir_sel, 1'b0, "fir high");
      u_host_cfg_model.wr(8'h2b, v & 8'h1f);
      u_host_cfg_model.io({8'h0, v[4:0], 3'h0});
      check(fir_sel, 1'b0, "fir off");
    end
    // Pins cleared first so no two sources ever share a number
    u_host_cfg_model.wr(8'h29, 8'h80);
    u_host_cfg_model.wr(8'h2a, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      n = 4'($urandom_range(1, 15));
      u_host_cfg_model.wr(8'h28,
        k == 0 ? {n, 4'h0} : k == 1 ? {4'h0, n} : 8'h0);
      u_host_cfg_model.wr(8'h29, {4'h8, k == 2 ? n : 4'h0});
      u_host_cfg_model.wr(8'h2a,
        k == 3 ? {4'h0, n} : k == 4 ? {n, 4'h0} : 8'h0);
      @(posedge clk_i);
      aux <= 2'b11;
      src <= 5'(1 << k);
      tick(3);
      check(lvl, 16'h1 << n, "irq level");
      check(drv, 16'h1 << n, "irq drive");
      @(posedge clk_i);
      src <= 5'h0;
      tick(3);
      check({lvl, drv}, {16'h0, 16'h1 << n}, "irq low");
    end
    u_host_cfg_model.wr(8'h28, 8'h00);
    u_host_cfg_model.wr(8'h29, 8'h80);
    u_host_cfg_model.wr(8'h2a, 8'h00);
    @(posedge clk_i);
    src <= 5'h1f;
    ir_mode <= 1'($urandom);
    tick(3);
    check(drv, 16'h0, "irq disabled");
    check({pin_oe, pin_o, fsel}, {1'b1, ir_mode, 1'b0}, "ir mode");
    u_host_cfg_model.wr(8'h29, 8'h10);
    @(posedge clk_i);
    pin_drv <= 1'b1;
    tick(3);
    check({pin_oe, third_rx, fsel, sirq_en}, 4'b0110, "rx3");
    @(posedge clk_i);
    pin_drv <= 1'b0;
    tick(3);
    check(third_rx, 1'b0, "rx3 low");
    end_of_test();
  end
endmodule
`default_nettype wire
